// ### verilog/asw_alu_status.sv
// Chosen here: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
module asw_alu_status
    import asw_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              instr_valid_i,
    input  wire logic [31:0]       instr_i,
    input  wire logic [31:0]       instr_addr_i,
    input  wire logic [31:0]       first_val_i,
    input  wire logic [31:0]       second_val_i,
    input  wire logic [31:0]       shift_val_i,
    output logic                   wr_en_o,
    output logic      [3:0]        wr_idx_o,
    output logic      [31:0]       wr_data_o,
    output logic                   pc_load_o,
    output logic      [31:0]       pc_value_o,
    output logic                   other_form_o,
    output logic      [31:0]       status_o,
    output logic                   model32_o,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o
);
    asw_state_t  state;
    asw_state_t  next_state;
    logic [31:0] saved;
    logic        sav_we;
    logic [31:0] sav_wdata;

    // pc as seen through the operand path
    function automatic logic [31:0] pc_view(input logic m32, input logic [31:0] addr,
                                            input logic [31:0] st, input logic keep);
        if (m32) begin
            return addr;
        end
        if (keep) begin
            return {st[ST_N:ST_V], st[ST_I], st[ST_F], addr[25:2], st[1:0]};
        end
        return {6'h00, addr[25:2], 2'h0};
    endfunction : pc_view

    // barrel shifter: {carry, value}
    function automatic logic [32:0] shift(input logic [31:0] v, input logic [1:0] typ,
                                          input logic [7:0] amt, input logic imm_form,
                                          input logic cin);
        logic [63:0] t;
        logic [7:0]  a;
        t = 64'h0;
        a = amt;
        if (amt == 8'h00 && !imm_form) begin
            return {cin, v};
        end
        case (typ)
            SH_LSL: begin
                if (amt == 8'h00) begin
                    return {cin, v};
                end
                t = {32'h00000000, v} << a;
                return {t[32], t[31:0]};
            end
            SH_LSR: begin
                if (amt == 8'h00) begin
                    a = 8'h20;
                end
                t = {v, 32'h00000000} >> a;
                return {t[31], t[63:32]};
            end
            SH_ASR: begin
                if (amt == 8'h00 || amt > 8'h20) begin
                    a = 8'h20;
                end
                t = $signed({v, 32'h00000000}) >>> a;
                return {t[31], t[63:32]};
            end
            SH_ROR: begin
                if (amt == 8'h00) begin
                    return {v[0], cin, v[31:1]};
                end
                t = {v, v} >> a[4:0];
                return {t[31], t[31:0]};
            end
            default: return {cin, v};
        endcase
    endfunction : shift

    // 8-bit immediate rotated right by twice the field
    function automatic logic [32:0] rot_imm(input logic [11:0] f, input logic cin);
        logic [63:0] t;
        t = {32'h000000FF & {24'h000000, f[7:0]}, 24'h000000, f[7:0]} >> {f[11:8], 1'b0};
        if (f[11:8] == 4'h0) begin
            return {cin, t[31:0]};
        end
        return {t[31], t[31:0]};
    endfunction : rot_imm

    // 26-bit status load from a result word
    function automatic logic [31:0] load26(input logic [31:0] st, input logic [31:0] r,
                                           input logic user);
        logic [31:0] s;
        s = st;
        s[ST_N:ST_V] = r[31:28];
        if (!user) begin
            s[ST_I] = r[R26_I];
            s[ST_F] = r[R26_F];
            s[1:0]  = r[1:0];
        end
        return s;
    endfunction : load26

    asw_saved_bank #(
        .WIDTH  (32),
        .ADDR_W (4)
    ) u_saved (
        .clk_i   (clk_i),
        .we_i    (sav_we),
        .waddr_i (state.status[3:0]),
        .wdata_i (sav_wdata),
        .raddr_i (next_state.status[3:0]),
        .rdata_o (saved)
    );

    always_comb begin
        logic [3:0]  opc;
        logic        sflag;
        logic [3:0]  rn;
        logic [3:0]  rd;
        logic [3:0]  rm;
        logic [3:0]  rs;
        logic        imm;
        logic        reg_shift;
        logic        user;
        logic        cin;
        logic        logical;
        logic        is_test;
        logic        upd_form;
        logic        xfer;
        logic [31:0] ahead;
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] sv;
        logic [32:0] op2;
        logic [31:0] x;
        logic [31:0] y;
        logic        ci;
        logic [32:0] sum;
        logic [31:0] res;
        logic        c_out;
        logic        v_out;
        logic [31:0] src;
        logic [31:0] st;
        opc       = instr_i[24:21];
        sflag     = instr_i[20];
        rn        = instr_i[19:16];
        rd        = instr_i[15:12];
        rm        = instr_i[3:0];
        rs        = instr_i[11:8];
        imm       = instr_i[25];
        reg_shift = !imm && instr_i[4];
        user      = state.status[3:0] == 4'h0;
        cin       = state.status[ST_C];
        next_state = state;
        next_state.wr_en      = 1'b0;
        next_state.pc_load    = 1'b0;
        next_state.other_form = 1'b0;
        sav_we    = 1'b0;
        sav_wdata = 32'h00000000;
        op2       = 33'h0;
        res       = 32'h00000000;
        // operand fetch with pc substitution
        ahead = reg_shift ? PC_AHEAD_LONG : PC_AHEAD_SHORT;
        a  = (rn == PC_REG) ? pc_view(state.model32, instr_addr_i + ahead, state.status, 1'b0)
                            : first_val_i;
        b  = (rm == PC_REG) ? pc_view(state.model32, instr_addr_i + ahead, state.status, 1'b1)
                            : second_val_i;
        sv = (rs == PC_REG) ? pc_view(state.model32, instr_addr_i + PC_AHEAD_SHORT, state.status, 1'b0)
                            : shift_val_i;
        if (imm) begin
            op2 = rot_imm(instr_i[11:0], cin);
        end else if (reg_shift) begin
            op2 = shift(b, instr_i[6:5], sv[7:0], 1'b0, cin);
        end else begin
            op2 = shift(b, instr_i[6:5], {3'h0, instr_i[11:7]}, 1'b1, cin);
        end
        // adder operand selection
        x  = a;
        y  = op2[31:0];
        ci = 1'b0;
        case (opc)
            OP_SUB, OP_CMP: begin
                y  = ~op2[31:0];
                ci = 1'b1;
            end
            OP_RSB: begin
                x  = op2[31:0];
                y  = ~a;
                ci = 1'b1;
            end
            OP_ADC: ci = cin;
            OP_SBC: begin
                y  = ~op2[31:0];
                ci = cin;
            end
            OP_RSC: begin
                x  = op2[31:0];
                y  = ~a;
                ci = cin;
            end
            default: ci = 1'b0;
        endcase
        sum = {1'b0, x} + {1'b0, y} + {32'h00000000, ci};
        logical = 1'b1;
        case (opc)
            OP_AND, OP_TST: res = a & op2[31:0];
            OP_EOR, OP_TEQ: res = a ^ op2[31:0];
            OP_ORR:         res = a | op2[31:0];
            OP_BIC:         res = a & ~op2[31:0];
            OP_MVN:         res = ~op2[31:0];
            4'hD:           res = op2[31:0];
            default: begin
                res     = sum[31:0];
                logical = 1'b0;
            end
        endcase
        c_out = logical ? op2[32] : sum[32];
        v_out = logical ? state.status[ST_V] : (x[31] == y[31]) && (sum[31] != x[31]);
        is_test  = opc[3:2] == 2'h2;
        upd_form = is_test && sflag && rd == PC_REG;
        xfer     = is_test && !sflag;
        src      = imm ? op2[31:0] : second_val_i;
        st       = state.status;
        if (instr_valid_i && instr_i[27:26] == 2'h0) begin
            if (reg_shift && instr_i[7]) begin
                next_state.other_form = 1'b1;
            end else if (xfer) begin
                if (!instr_i[21]) begin
                    next_state.wr_en   = 1'b1;
                    next_state.wr_idx  = rd;
                    next_state.wr_data = instr_i[22] ? saved : state.status;
                end else if (!instr_i[16]) begin
                    if (instr_i[22]) begin
                        sav_we    = !user;
                        sav_wdata = {src[31:28], saved[27:0]};
                    end else begin
                        next_state.status[ST_N:ST_V] = src[31:28];
                    end
                end else if (instr_i[22]) begin
                    sav_we    = !user;
                    sav_wdata = src;
                end else if (user) begin
                    next_state.status[ST_N:ST_V] = src[31:28];
                end else begin
                    next_state.status = src;
                end
            end else begin
                next_state.last = res;
                if (upd_form) begin
                    if (!state.model32) begin
                        next_state.status = load26(st, res, user);
                    end else if (opc == OP_TEQ && !user) begin
                        next_state.status = saved;
                    end else begin
                        next_state.status[ST_N:ST_V] = res[31:28];
                    end
                end else if (rd == PC_REG && !is_test) begin
                    next_state.pc_load  = 1'b1;
                    next_state.pc_value = state.model32 ? res : {6'h00, res[25:2], 2'h0};
                    if (sflag && !state.model32) begin
                        next_state.status = load26(st, res, user);
                    end else if (sflag && !user) begin
                        next_state.status = saved;
                    end
                end else begin
                    if (!is_test) begin
                        next_state.wr_en   = 1'b1;
                        next_state.wr_idx  = rd;
                        next_state.wr_data = res;
                    end
                    if (sflag) begin
                        next_state.status[ST_N] = res[31];
                        next_state.status[ST_Z] = res == 32'h00000000;
                        next_state.status[ST_C] = c_out;
                        next_state.status[ST_V] = v_out;
                    end
                end
            end
        end
        // wishbone slave, one wait state, unmapped reads return zero
        next_state.ack = wb_cyc_i && wb_stb_i && !state.ack;
        if (wb_cyc_i && wb_stb_i && !state.ack) begin
            next_state.dat = 32'h00000000;
            case (wb_adr_i[7:0])
                ADR_CTRL: begin
                    next_state.dat[CTRL_MODEL32] = state.model32;
                    if (wb_we_i && wb_sel_i[0]) begin
                        next_state.model32 = wb_dat_i[CTRL_MODEL32];
                    end
                end
                ADR_STATUS: next_state.dat = state.status;
                ADR_SAVED:  next_state.dat = saved;
                ADR_RESULT: next_state.dat = state.last;
                default:    next_state.dat = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state         <= '0;
            state.model32 <= MODEL32_RST;
            state.status  <= STATUS_RST;
        end else begin
            state <= next_state;
        end
    end

    assign wr_en_o      = state.wr_en;
    assign wr_idx_o     = state.wr_idx;
    assign wr_data_o    = state.wr_data;
    assign pc_load_o    = state.pc_load;
    assign pc_value_o   = state.pc_value;
    assign other_form_o = state.other_form;
    assign status_o     = state.status;
    assign model32_o    = state.model32;
    assign wb_dat_o     = state.dat;
    assign wb_ack_o     = state.ack;
endmodule : asw_alu_status
`default_nettype wire

// ### verilog/asw_pkg.sv
`default_nettype none
package asw_pkg;
    // register offsets on the bus
    localparam logic [7:0]  ADR_CTRL       = 8'h00;
    localparam logic [7:0]  ADR_STATUS     = 8'h04;
    localparam logic [7:0]  ADR_SAVED      = 8'h08;
    localparam logic [7:0]  ADR_RESULT     = 8'h0C;
    localparam int          CTRL_MODEL32   = 0;
    localparam logic        MODEL32_RST    = 1'b0;
    // status word layout
    localparam int          ST_N           = 31;
    localparam int          ST_Z           = 30;
    localparam int          ST_C           = 29;
    localparam int          ST_V           = 28;
    localparam int          ST_I           = 7;
    localparam int          ST_F           = 6;
    localparam logic [31:0] STATUS_RST     = 32'h000000D3;
    // result bits copied in the 26-bit model
    localparam int          R26_I          = 27;
    localparam int          R26_F          = 26;
    // opcodes
    localparam logic [3:0]  OP_AND         = 4'h0;
    localparam logic [3:0]  OP_EOR         = 4'h1;
    localparam logic [3:0]  OP_SUB         = 4'h2;
    localparam logic [3:0]  OP_RSB         = 4'h3;
    localparam logic [3:0]  OP_ADD         = 4'h4;
    localparam logic [3:0]  OP_ADC         = 4'h5;
    localparam logic [3:0]  OP_SBC         = 4'h6;
    localparam logic [3:0]  OP_RSC         = 4'h7;
    localparam logic [3:0]  OP_TST         = 4'h8;
    localparam logic [3:0]  OP_TEQ         = 4'h9;
    localparam logic [3:0]  OP_CMP         = 4'hA;
    localparam logic [3:0]  OP_CMN         = 4'hB;
    localparam logic [3:0]  OP_ORR         = 4'hC;
    localparam logic [3:0]  OP_BIC         = 4'hE;
    localparam logic [3:0]  OP_MVN         = 4'hF;
    localparam logic [3:0]  PC_REG         = 4'hF;
    localparam logic [31:0] PC_AHEAD_SHORT = 32'h00000008;
    localparam logic [31:0] PC_AHEAD_LONG  = 32'h0000000C;
    localparam logic [1:0]  SH_LSL         = 2'h0;
    localparam logic [1:0]  SH_LSR         = 2'h1;
    localparam logic [1:0]  SH_ASR         = 2'h2;
    localparam logic [1:0]  SH_ROR         = 2'h3;

    typedef struct packed {
        logic        model32;
        logic [31:0] status;
        logic [31:0] last;
        logic        wr_en;
        logic [3:0]  wr_idx;
        logic [31:0] wr_data;
        logic        pc_load;
        logic [31:0] pc_value;
        logic        other_form;
        logic        ack;
        logic [31:0] dat;
    } asw_state_t;
endpackage : asw_pkg
`default_nettype wire

// ### verilog/asw_saved_bank.sv
`timescale 1ns/1ns
`default_nettype none
module asw_saved_bank #(
    parameter int WIDTH  = 32,
    parameter int ADDR_W = 4
) (
    input  wire logic              clk_i,
    input  wire logic              we_i,
    input  wire logic [ADDR_W-1:0] waddr_i,
    input  wire logic [WIDTH-1:0]  wdata_i,
    input  wire logic [ADDR_W-1:0] raddr_i,
    output logic      [WIDTH-1:0]  rdata_o
);
    logic [WIDTH-1:0] mem [2**ADDR_W];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        // write-through so a same-cycle update is seen at once
        if (we_i && waddr_i == raddr_i) begin
            rdata_o <= wdata_i;
        end else begin
            rdata_o <= mem[raddr_i];
        end
    end
endmodule : asw_saved_bank
`default_nettype wire

// ### tb/asw_alu_status_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module asw_chk
    import asw_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        instr_valid_i,
    input wire logic [31:0] instr_i,
    input wire logic [31:0] instr_addr_i,
    input wire logic [31:0] first_val_i,
    input wire logic [31:0] second_val_i,
    input wire logic        wr_en_o,
    input wire logic [3:0]  wr_idx_o,
    input wire logic [31:0] wr_data_o,
    input wire logic        pc_load_o,
    input wire logic        other_form_o,
    input wire logic [31:0] status_o,
    input wire logic        model32_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [63:0] dbl;
    logic [31:0] imm, res, upd, flg, usr, pcx;
    logic [3:0]  opc;
    logic        take, xfer, rdpc, sbit;
    assign dbl  = {2{24'h000000, instr_i[7:0]}} >> {instr_i[11:8], 1'h0};
    assign imm  = dbl[31:0];
    assign opc  = instr_i[24:21];
    assign sbit = instr_i[20];
    assign rdpc = instr_i[15:12] == PC_REG;
    assign take = instr_valid_i && instr_i[27:26] == 2'h0 && !(!instr_i[25] && instr_i[7] && instr_i[4]);
    assign xfer = take && instr_i[24:23] == 2'h2 && !sbit;
    assign res  = first_val_i ^ imm;
    // user mode keeps control bits, other modes load them from the result
    assign upd  = status_o[3:0] == 4'h0 ? {res[31:28], status_o[27:0]}
                : {res[31:28], status_o[27:8], res[27:26], status_o[5:2], res[1:0]};
    assign flg  = {imm[31:28], status_o[27:0]};
    assign usr  = {second_val_i[31:28], status_o[27:0]};
    assign pcx  = (instr_addr_i + PC_AHEAD_SHORT) & 32'h03FFFFFC;
    imm_rot_a: assert property (
        take && instr_i[25] && opc == 4'hD && !sbit && !rdpc
        |=> wr_en_o && wr_data_o == $past(imm) && wr_idx_o == $past(instr_i[15:12])) else $error("bad immediate");
    other_form_a: assert property (
        instr_valid_i && instr_i[27:25] == 3'h0 && instr_i[7] && instr_i[4]
        |=> other_form_o && !wr_en_o && !pc_load_o) else $error("bit 7 form handled");
    status_keep_a: assert property (
        take && !sbit && opc[3:2] != 2'h2
        |=> status_o == $past(status_o) && pc_load_o == $past(rdpc)) else $error("status moved");
    update_form_a: assert property (
        take && instr_i[25] && opc == OP_TEQ && sbit && rdpc && !model32_o && instr_i[19:16] != PC_REG
        |=> status_o == $past(upd)) else $error("update form wrong");
    pc_first_a: assert property (
        take && instr_i[25] && opc == OP_ADD && instr_i[11:0] == 12'h000 && instr_i[19:16] == PC_REG
        && !rdpc && !model32_o |=> wr_data_o == $past(pcx)) else $error("pc first operand wrong");
    flags_only_a: assert property (
        xfer && instr_i[25] && instr_i[21] && !instr_i[22] && !instr_i[16]
        |=> status_o == $past(flg)) else $error("flag write wrong");
    user_whole_a: assert property (
        xfer && !instr_i[25] && instr_i[21] && !instr_i[22] && instr_i[16] && status_o[3:0] == 4'h0
        |=> status_o == $past(usr)) else $error("user whole write wrong");
    status_read_a: assert property (
        xfer && !instr_i[21] && !instr_i[22]
        |=> wr_en_o && wr_data_o == $past(status_o)) else $error("status read wrong");
endmodule : asw_chk
`default_nettype wire

// ### tb/asw_regfile_model.sv
`timescale 1ns/1ns
`default_nettype none
module asw_regfile_model (
    input  wire logic        clk_i,
    input  wire logic [31:0] instr_i,
    input  wire logic        wr_en_i,
    input  wire logic [3:0]  wr_idx_i,
    input  wire logic [31:0] wr_data_i,
    output logic      [31:0] first_val_o,
    output logic      [31:0] second_val_o,
    output logic      [31:0] shift_val_o
);
    logic [31:0] regs [16];
    // the pc slot holds a changing pattern, so the core must substitute its own value
    initial regs[15] = 32'h5A5A5A5A;
    always @(posedge clk_i) begin
        if (wr_en_i) begin
            regs[wr_idx_i] <= wr_data_i;
        end
        regs[15] <= ~regs[15];
    end
    assign first_val_o  = regs[instr_i[19:16]];
    assign second_val_o = regs[instr_i[3:0]];
    assign shift_val_o  = regs[instr_i[11:8]];
endmodule : asw_regfile_model
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench import asw_pkg::*;;
    logic        clk_i, rst_i, instr_valid_i, wb_cyc_i, wb_stb_i, wb_we_i;
    logic        wr_en_o, pc_load_o, other_form_o, model32_o, wb_ack_o;
    logic [3:0]  wr_idx_o, wb_sel_i;
    logic [7:0]  wb_adr_i;
    logic [31:0] instr_i, instr_addr_i, first_val_i, second_val_i, shift_val_i;
    logic [31:0] wr_data_o, pc_value_o, status_o, wb_dat_i, wb_dat_o, q;
    int          fail_count = 0;
    int          num_checks = 0;
    asw_regfile_model pm (.clk_i, .instr_i, .wr_en_i(wr_en_o), .wr_idx_i(wr_idx_o), .wr_data_i(wr_data_o),
        .first_val_o(first_val_i), .second_val_o(second_val_i), .shift_val_o(shift_val_i));
    asw_alu_status DUT (.clk_i, .rst_i, .instr_valid_i, .instr_i, .instr_addr_i, .first_val_i, .second_val_i,
        .shift_val_i, .wr_en_o, .wr_idx_o, .wr_data_o, .pc_load_o, .pc_value_o, .other_form_o, .status_o,
        .model32_o, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic close_out();
        if (fail_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= d;
        // the wait ends on wb_ack_o; only the watchdog ends a wait that never gets an answer
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'h1);
        q = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
    endtask : wb
    task automatic exe(input logic [31:0] ins);
        @(posedge clk_i);
        instr_valid_i <= 1'h1;
        instr_i       <= ins;
        @(posedge clk_i);
        instr_valid_i <= 1'h0;
        #1;
    endtask : exe
    task automatic res(input logic [31:0] ins, input logic [3:0] idx, input logic [31:0] d);
        exe(ins);
        chk("wr_en", 32'h1, wr_en_o);
        chk("wr_idx", idx, wr_idx_o);
        chk("wr_data", d, wr_data_o);
    endtask : res
    initial begin
        clk_i = 1'h0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        #20000;
        fail_count++;
        close_out();
    end
    initial begin
        rst_i         = 1'h1;
        instr_valid_i = 1'h0;
        wb_cyc_i      = 1'h0;
        wb_stb_i      = 1'h0;
        wb_we_i       = 1'h0;
        wb_sel_i      = 4'hF;
        wb_adr_i      = 8'h00;
        wb_dat_i      = 32'h0;
        instr_i       = 32'h0;
        instr_addr_i  = 32'h00000100;
        for (int i = 0; i < 15; i++) pm.regs[i] = 32'h0;
        pm.regs[1] = 32'hFFFFFFFF;
        pm.regs[2] = 32'h12345678;
        pm.regs[3] = 32'h00000008;
        pm.regs[4] = 32'h5000001F;
        pm.regs[6] = 32'h80000010;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'h0;
        chk("status", STATUS_RST, status_o);
        res(32'hE3A004FF, 4'h0, 32'hFF000000);
        res(32'hE3A00FFF, 4'h0, 32'h000003FC);
        res(32'hE1A00202, 4'h0, 32'h23456780);
        res(32'hE1A00332, 4'h0, 32'h00123456);
        exe(32'hE1A00392);
        chk("other_form", 32'h1, other_form_o);
        chk("wr_en", 32'h0, wr_en_o);
        res(32'hE28F0000, 4'h0, 32'h00000108);
        res(32'hE1A0000F, 4'h0, 32'h0C00010B);
        res(32'hE1A0071F, 4'h0, 32'h0C00010F);
        res(32'hE1A00F12, 4'h0, 32'h34567800);
        exe(32'hE338F4A4);
        chk("status", 32'hA0000050, status_o);
        exe(32'hE1A00000);
        exe(32'hE338F30F);
        chk("status", 32'h30000050, status_o);
        exe(32'hE2810001);
        chk("status", 32'h30000050, status_o);
        exe(32'hE2910001);
        chk("status", 32'h60000050, status_o);
        exe(32'hE1A0F002);
        chk("pc_load", 32'h1, pc_load_o);
        chk("pc_value", 32'h02345678, pc_value_o);
        chk("status", 32'h60000050, status_o);
        exe(32'hE1B0F001);
        chk("status", 32'hF0000050, status_o);
        rst_i <= 1'h1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'h0;
        wb(1'h1, ADR_CTRL, 32'h1);
        wb(1'h0, ADR_CTRL, 32'h0);
        chk("ctrl", 32'h1, q);
        #1;
        chk("ack_drop", 32'h0, wb_ack_o);
        chk("model32", 32'h1, model32_o);
        wb(1'h1, ADR_STATUS, 32'h0);
        wb(1'h0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, q);
        wb(1'h0, ADR_STATUS, 32'h0);
        chk("status_rd", STATUS_RST, q);
        exe(32'hE169F004);
        res(32'hE14F5000, 4'h5, 32'h5000001F);
        res(32'hE10F5000, 4'h5, STATUS_RST);
        exe(32'hE328F4A0);
        chk("status", 32'hA00000D3, status_o);
        exe(32'hE1A0F002);
        chk("pc_load", 32'h1, pc_load_o);
        chk("pc_value", 32'h12345678, pc_value_o);
        chk("status", 32'hA00000D3, status_o);
        exe(32'hE1B0F001);
        chk("status", 32'h5000001F, status_o);
        exe(32'hE169F006);
        exe(32'hE338F000);
        chk("status", 32'h80000010, status_o);
        exe(32'hE1A00000);
        exe(32'hE129F004);
        chk("status", 32'h50000010, status_o);
        close_out();
    end
endmodule : testbench
bind asw_alu_status asw_chk u_chk (.clk_i, .rst_i, .instr_valid_i, .instr_i, .instr_addr_i, .first_val_i,
    .second_val_i, .wr_en_o, .wr_idx_o, .wr_data_o, .pc_load_o, .other_form_o, .status_o, .model32_o);
`default_nettype wire
